// ==== hdl/rtc_consts.svh ====
// register offsets, field positions, reset values and timing counts of the real-time counter
`ifndef RTC_CONSTS_SVH
`define RTC_CONSTS_SVH

`define RTC_ADDR_W 4
`define RTC_OFF_CTRL 4'h0
`define RTC_OFF_STATUS 4'h1
`define RTC_OFF_EVEN 4'h2
`define RTC_OFF_FLAGS 4'h3
`define RTC_OFF_SHADOW 4'h4
`define RTC_OFF_HALT 4'h5
`define RTC_OFF_SRC 4'h7
`define RTC_OFF_CNT_LO 4'h8
`define RTC_OFF_CNT_HI 4'h9
`define RTC_OFF_TOP_LO 4'ha
`define RTC_OFF_TOP_HI 4'hb
`define RTC_OFF_CMP_LO 4'hc
`define RTC_OFF_CMP_HI 4'hd

`define RTC_CTRL_RUNSLEEP 7
`define RTC_CTRL_DIV_HI 6
`define RTC_CTRL_DIV_LO 3
`define RTC_CTRL_EN 0
`define RTC_CTRL_MASK 8'hf9

`define RTC_BIT_MATCH 1
`define RTC_BIT_WRAP 0
`define RTC_BIT_RUN_WHILE_HALTED 0

`define RTC_SYNC_CTRL 0
`define RTC_SYNC_CNT 1
`define RTC_SYNC_TOP 2
`define RTC_SYNC_CMP 3
`define RTC_SYNC_N 4

`define RTC_CTRL_RST 8'h00
`define RTC_CNT_RST 16'h0000
`define RTC_TOP_RST 16'hffff
`define RTC_CMP_RST 16'h0000
`define RTC_BYTE_RST 8'h00

`define RTC_SYNC_LAT 2'h2
`define RTC_PRESC_W 15

`endif

// ==== hdl/rtc_pkg.sv ====
// types shared by the real-time counter
package rtc_pkg;
	typedef logic [7:0] rtc_byte_t;
	typedef logic [15:0] rtc_word_t;
	typedef enum logic [1:0] {
		RTC_SRC_LP_RC,
		RTC_SRC_LP_RC_1K,
		RTC_SRC_CRYSTAL,
		RTC_SRC_EXT_PIN
	} rtc_src_t;
endpackage

// ==== hdl/rtc_counter_registers.sv ====
// real-time counter with byte-wide registers, shadowed 16-bit access and sync latency
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "rtc_consts.svh"

// Operation
// - prescale timebase by two to the code
// - control write applies two timebase ticks later
// - bit 7 keeps counting in standby
// - bit 0 enables the counter
// - status bit 3 shows compare write pending
// - status bit 2 shows top write pending
// - status bit 1 shows count write pending
// - status bit 0 control pending, status read-only
// - enable bit 1 gates match request
// - enable bit 0 gates wrap request
// - count up, wrap to zero after top
// - match sets flag 1, write one clears
// - wrap sets flag 0, write one clears
// - shared shadow byte makes 16-bit access atomic
// - halted debug stops counter unless run bit
// - two-bit field selects the timebase source
// - low byte at base, high at plus one
// - count write applies two timebase ticks later
// - top resets to ones, two-tick latency
// - idle sleep never stops the counter
module rtc_counter_registers #(
	parameter int CNT_W = 16,
	parameter int PRESC_W = `RTC_PRESC_W
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [`RTC_ADDR_W-1:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	input wire logic tickLpRc,
	input wire logic tickLpRc1k,
	input wire logic tickCrystal,
	input wire logic tickExtPin,
	input wire logic inIdle,
	input wire logic inStandby,
	input wire logic cpuHalted,
	output logic irqReq,
	output logic matchEvent,
	output logic wrapEvent
);
	rtc_pkg::rtc_byte_t ctrlSw_r;
	rtc_pkg::rtc_byte_t ctrlAct_r;
	rtc_pkg::rtc_byte_t shadow_r;
	rtc_pkg::rtc_byte_t rdData_r;
	rtc_pkg::rtc_word_t cntStage_r;
	rtc_pkg::rtc_word_t topSw_r;
	rtc_pkg::rtc_word_t topAct_r;
	rtc_pkg::rtc_word_t cmpSw_r;
	rtc_pkg::rtc_word_t cmpAct_r;
	rtc_pkg::rtc_src_t src_r;
	logic [CNT_W-1:0] count_r;
	logic [PRESC_W-1:0] presc_r;
	logic [1:0] evEnable_r;
	logic [1:0] flags_r;
	logic run_while_halted_r;
	logic irq_r;
	logic matchEv_r;
	logic wrapEv_r;
	logic tbTick;
	logic presTick;
	logic runOk;
	logic hitTop;
	logic hitCmp;
	logic [PRESC_W-1:0] divMask;
	logic [`RTC_SYNC_N-1:0] syncStart;
	logic [`RTC_SYNC_N-1:0] syncApply;
	logic [`RTC_SYNC_N-1:0] syncBusy;
	logic [3:0] divCode;

	wire wrCtrl = regWr && regAddr == `RTC_OFF_CTRL;
	wire wrCntHi = regWr && regAddr == `RTC_OFF_CNT_HI;
	wire wrTopHi = regWr && regAddr == `RTC_OFF_TOP_HI;
	wire wrCmpHi = regWr && regAddr == `RTC_OFF_CMP_HI;

	// source choice of the timebase tick
	always_comb begin
		unique case (src_r)
			rtc_pkg::RTC_SRC_LP_RC: tbTick = tickLpRc;
			rtc_pkg::RTC_SRC_LP_RC_1K: tbTick = tickLpRc1k;
			rtc_pkg::RTC_SRC_CRYSTAL: tbTick = tickCrystal;
			rtc_pkg::RTC_SRC_EXT_PIN: tbTick = tickExtPin;
		endcase
	end

	// mask of 2^code - 1 low bits; code 0 passes every tick
	assign divCode = ctrlAct_r[`RTC_CTRL_DIV_HI:`RTC_CTRL_DIV_LO];
	assign divMask = PRESC_W'((32'h1 << divCode) - 32'h1);
	assign presTick = tbTick && ((presc_r & divMask) == divMask);

	// idle never stops; standby needs the run bit; halt needs debug run
	assign runOk = ctrlAct_r[`RTC_CTRL_EN]
		&& !(inStandby && !inIdle && !ctrlAct_r[`RTC_CTRL_RUNSLEEP])
		&& !(cpuHalted && !run_while_halted_r);
	assign hitTop = presTick && runOk && count_r == CNT_W'(topAct_r);
	assign hitCmp = presTick && runOk && count_r == CNT_W'(cmpAct_r);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			presc_r <= '0;
		end else if (!ctrlAct_r[`RTC_CTRL_EN]) begin
			presc_r <= '0;
		end else if (tbTick && runOk) begin
			presc_r <= presc_r + PRESC_W'(1);
		end
	end

	// synchronisation latency, one countdown per shadowed register
	assign syncStart[`RTC_SYNC_CTRL] = wrCtrl;
	assign syncStart[`RTC_SYNC_CNT] = wrCntHi;
	assign syncStart[`RTC_SYNC_TOP] = wrTopHi;
	assign syncStart[`RTC_SYNC_CMP] = wrCmpHi;

	genvar gi;
	generate
		for (gi = 0; gi < `RTC_SYNC_N; gi++) begin : gSync
			logic [1:0] left_r;
			// a rewrite while busy restarts the wait rather than being lost
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					left_r <= 2'h0;
				end else if (syncStart[gi]) begin
					left_r <= `RTC_SYNC_LAT;
				end else if (tbTick && left_r != 2'h0) begin
					left_r <= left_r - 2'h1;
				end
			end
			assign syncApply[gi] = !syncStart[gi] && tbTick && left_r == 2'h1;
			assign syncBusy[gi] = left_r != 2'h0;
		end
	endgenerate

	// counter: staged writes win over counting
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_r <= CNT_W'(`RTC_CNT_RST);
		end else if (syncApply[`RTC_SYNC_CNT]) begin
			count_r <= CNT_W'(cntStage_r);
		end else if (hitTop) begin
			count_r <= '0;
		end else if (presTick && runOk) begin
			count_r <= count_r + CNT_W'(1);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrlAct_r <= `RTC_CTRL_RST;
			topAct_r <= `RTC_TOP_RST;
			cmpAct_r <= `RTC_CMP_RST;
		end else begin
			if (syncApply[`RTC_SYNC_CTRL]) begin
				ctrlAct_r <= ctrlSw_r;
			end
			if (syncApply[`RTC_SYNC_TOP]) begin
				topAct_r <= topSw_r;
			end
			if (syncApply[`RTC_SYNC_CMP]) begin
				cmpAct_r <= cmpSw_r;
			end
		end
	end

	// software-side registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrlSw_r <= `RTC_CTRL_RST;
			evEnable_r <= 2'h0;
			run_while_halted_r <= 1'b0;
			src_r <= rtc_pkg::RTC_SRC_LP_RC;
			cntStage_r <= `RTC_CNT_RST;
			topSw_r <= `RTC_TOP_RST;
			cmpSw_r <= `RTC_CMP_RST;
		end else if (regWr) begin
			unique case (regAddr)
				`RTC_OFF_CTRL: ctrlSw_r <= regWrData & `RTC_CTRL_MASK;
				`RTC_OFF_EVEN: evEnable_r <= regWrData[1:0];
				`RTC_OFF_HALT: run_while_halted_r <= regWrData[`RTC_BIT_RUN_WHILE_HALTED];
				`RTC_OFF_SRC: src_r <= rtc_pkg::rtc_src_t'(regWrData[1:0]);
				`RTC_OFF_CNT_HI: cntStage_r <= {regWrData, shadow_r};
				`RTC_OFF_TOP_HI: topSw_r <= {regWrData, shadow_r};
				`RTC_OFF_CMP_HI: cmpSw_r <= {regWrData, shadow_r};
				default: begin
				end
			endcase
		end
	end

	// shadow byte: low-byte write parks data, low-byte read parks the high half
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shadow_r <= `RTC_BYTE_RST;
		end else if (regWr && (regAddr == `RTC_OFF_SHADOW || regAddr == `RTC_OFF_CNT_LO
				|| regAddr == `RTC_OFF_TOP_LO || regAddr == `RTC_OFF_CMP_LO)) begin
			shadow_r <= regWrData;
		end else if (regRd) begin
			unique case (regAddr)
				`RTC_OFF_CNT_LO: shadow_r <= 8'(count_r >> 8);
				`RTC_OFF_TOP_LO: shadow_r <= topSw_r[15:8];
				`RTC_OFF_CMP_LO: shadow_r <= cmpSw_r[15:8];
				default: begin
				end
			endcase
		end
	end

	// flags: a hardware set beats a same-cycle write-one clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_r <= 2'h0;
		end else begin
			flags_r[`RTC_BIT_MATCH] <= hitCmp
				|| (flags_r[`RTC_BIT_MATCH]
				&& !(regWr && regAddr == `RTC_OFF_FLAGS && regWrData[`RTC_BIT_MATCH]));
			flags_r[`RTC_BIT_WRAP] <= hitTop
				|| (flags_r[`RTC_BIT_WRAP]
				&& !(regWr && regAddr == `RTC_OFF_FLAGS && regWrData[`RTC_BIT_WRAP]));
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_r <= 1'b0;
			matchEv_r <= 1'b0;
			wrapEv_r <= 1'b0;
		end else begin
			irq_r <= |(flags_r & evEnable_r);
			matchEv_r <= hitCmp;
			wrapEv_r <= hitTop;
		end
	end

	// read data stand only in the cycle after the strobe; unmapped reads zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdData_r <= `RTC_BYTE_RST;
		end else if (regRd) begin
			unique case (regAddr)
				`RTC_OFF_CTRL: rdData_r <= ctrlSw_r;
				`RTC_OFF_STATUS: rdData_r <= {4'h0, syncBusy};
				`RTC_OFF_EVEN: rdData_r <= {6'h00, evEnable_r};
				`RTC_OFF_FLAGS: rdData_r <= {6'h00, flags_r};
				`RTC_OFF_SHADOW: rdData_r <= shadow_r;
				`RTC_OFF_HALT: rdData_r <= {7'h00, run_while_halted_r};
				`RTC_OFF_SRC: rdData_r <= {6'h00, src_r};
				`RTC_OFF_CNT_LO: rdData_r <= count_r[7:0];
				`RTC_OFF_TOP_LO: rdData_r <= topSw_r[7:0];
				`RTC_OFF_CMP_LO: rdData_r <= cmpSw_r[7:0];
				`RTC_OFF_CNT_HI, `RTC_OFF_TOP_HI, `RTC_OFF_CMP_HI: rdData_r <= shadow_r;
				default: rdData_r <= 8'h00;
			endcase
		end else begin
			rdData_r <= 8'h00;
		end
	end

	assign regRdData = rdData_r;
	assign irqReq = irq_r;
	assign matchEvent = matchEv_r;
	assign wrapEvent = wrapEv_r;
endmodule

// ==== test/rcr_chk.sv ====
// port-level assertions for the real-time counter
`timescale 1ns/1ps
`include "rtc_consts.svh"
module rcr_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [`RTC_ADDR_W-1:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdData,
	input wire logic tickLpRc,
	input wire logic tickLpRc1k,
	input wire logic tickCrystal,
	input wire logic tickExtPin,
	input wire logic cpuHalted,
	input wire logic irqReq,
	input wire logic matchEvent,
	input wire logic wrapEvent
);
	logic [1:0] evEn_r;
	logic run_while_halted_r;
	logic anyTick;
	assign anyTick = tickLpRc | tickLpRc1k | tickCrystal | tickExtPin;
	// shadow copies of the enables, so masking can be judged from the bus alone
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) evEn_r <= 2'h0;
		else if (regWr && regAddr == `RTC_OFF_EVEN) evEn_r <= regWrData[1:0];
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) run_while_halted_r <= 1'b0;
		else if (regWr && regAddr == `RTC_OFF_HALT) run_while_halted_r <= regWrData[0];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence sWr(a); regWr && regAddr == a; endsequence
	sequence sStat; regRd && regAddr == `RTC_OFF_STATUS; endsequence
	property pBusy(a, b); sWr(a) ##1 sStat |=> regRdData[b]; endproperty
	AST_BUSY_CTRL: assert property (pBusy(`RTC_OFF_CTRL, 0))
		else $error("control write not busy");
	AST_BUSY_CNT: assert property (pBusy(`RTC_OFF_CNT_HI, 1))
		else $error("count write not busy");
	AST_BUSY_TOP: assert property (pBusy(`RTC_OFF_TOP_HI, 2))
		else $error("top write not busy");
	AST_BUSY_CMP: assert property (pBusy(`RTC_OFF_CMP_HI, 3))
		else $error("compare write not busy");
	AST_STAT_RSVD: assert property (sStat |=> regRdData[7:4] == 4'h0)
		else $error("status upper bits set");
	AST_IRQ_WRAP: assert property (wrapEvent && evEn_r[0] |=> irqReq)
		else $error("wrap request missing");
	AST_IRQ_MATCH: assert property (matchEvent && evEn_r[1] |=> irqReq)
		else $error("match request missing");
	AST_IRQ_MASK: assert property ($past(evEn_r) == 2'h0 |-> !irqReq)
		else $error("request while masked");
	AST_NO_TICK: assert property (!$past(anyTick) && !$past(anyTick, 2) |->
		!wrapEvent && !matchEvent) else $error("event without tick");
	AST_HALT: assert property ($past(cpuHalted && !run_while_halted_r) &&
		$past(cpuHalted && !run_while_halted_r, 2) |-> !wrapEvent && !matchEvent)
		else $error("event while halted");
endmodule
bind rtc_counter_registers rcr_chk u_chk (.*);

// ==== test/test_rtc_counter_registers.sv ====
// self-checking bench for the real-time counter
`timescale 1ns/1ps
module test_rtc_counter_registers;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWrData = 8'h00;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [7:0] regRdData;
	logic [3:0] ticks = 4'h0;
	logic inIdle = 1'b0;
	logic inStandby = 1'b0;
	logic cpuHalted = 1'b0;
	logic irqReq;
	logic matchEvent;
	logic wrapEvent;
	logic rdV = 1'b0;
	logic [7:0] expQ[$];
	logic [15:0] t;
	int miscompares = 0;
	int comparisons = 0;
	int seed = 32'hff0f592f;
	int src = 0;
	int i;
	always #25 clk = ~clk;
	rtc_counter_registers u_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.tickLpRc(ticks[0]), .tickLpRc1k(ticks[1]),
		.tickCrystal(ticks[2]), .tickExtPin(ticks[3]), .inIdle(inIdle),
		.inStandby(inStandby), .cpuHalted(cpuHalted), .irqReq(irqReq),
		.matchEvent(matchEvent), .wrapEvent(wrapEvent));
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// read data stand only in the cycle after the strobe, so judge them there
	always @(posedge clk) begin
		if (rdV) chk({8'h00, regRdData}, expQ.pop_front());
		rdV <= regRd;
	end
	task test_done;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		regRd <= 1'b0;
		@(posedge clk);
	endtask
	task rdc(input logic [3:0] a, input logic [7:0] e);
		regAddr <= a;
		regRd <= 1'b1;
		regWr <= 1'b0;
		expQ.push_back(e);
		@(posedge clk);
	endtask
	task w16(input logic [3:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 4'h1, v[15:8]);
	endtask
	task r16(input logic [3:0] a, input logic [15:0] v);
		rdc(a, v[7:0]);
		rdc(a + 4'h1, v[15:8]);
	endtask
	// selected source pulses; noise only ever lands on unselected sources
	task tk(input int n);
		repeat (n) begin
			regWr <= 1'b0;
			regRd <= 1'b0;
			ticks <= 4'h1 << src;
			@(posedge clk);
			ticks <= 4'($random(seed)) & ~(4'h1 << src);
			@(posedge clk);
		end
		ticks <= 4'h0;
	endtask
	task cirq(input logic e);
		regWr <= 1'b0;
		regRd <= 1'b0;
		@(negedge clk);
		chk({15'h0, irqReq}, {15'h0, e});
		@(posedge clk);
	endtask
	initial begin
		#2000000;
		miscompares++;
		test_done;
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 16; i++) rdc(i[3:0], (i == 10 || i == 11) ? 8'hff : 8'h00);
		wr(4'h4, 8'h5a);
		rdc(4'h4, 8'h5a);
		for (i = 0; i < 4; i++) begin
			wr(4'h0, {1'b0, i[3:0], 3'b001});
			rdc(4'h1, 8'h01);
			tk(2);
			rdc(4'h1, 8'h00);
			w16(4'h8, 16'h0000);
			rdc(4'h1, 8'h02);
			tk(2 + (2 << i));
			r16(4'h8, 16'h0002);
		end
		t = 16'h3 + 16'($random(seed) & 7);
		w16(4'ha, t);
		rdc(4'h1, 8'h04);
		wr(4'h0, 8'h01);
		tk(2);
		w16(4'h8, t - 16'h2);
		tk(2);
		wr(4'h3, 8'h03);
		wr(4'h2, 8'h01);
		tk(2);
		r16(4'h8, t);
		rdc(4'h3, 8'h00);
		tk(1);
		rdc(4'h3, 8'h01);
		r16(4'h8, 16'h0000);
		cirq(1'b1);
		wr(4'h3, 8'h01);
		wr(4'h2, 8'h02);
		w16(4'hc, t - 16'h1);
		rdc(4'h1, 8'h08);
		tk(2);
		wr(4'h3, 8'h03);
		tk(int'(t) - 3);
		rdc(4'h3, 8'h00);
		cirq(1'b0);
		tk(1);
		rdc(4'h3, 8'h02);
		cirq(1'b1);
		wr(4'h3, 8'h01);
		rdc(4'h3, 8'h02);
		wr(4'h3, 8'h02);
		rdc(4'h3, 8'h00);
		w16(4'h8, 16'h0000);
		tk(2);
		cpuHalted <= 1'b1;
		tk(3);
		r16(4'h8, 16'h0000);
		wr(4'h5, 8'h01);
		tk(1);
		r16(4'h8, 16'h0001);
		cpuHalted <= 1'b0;
		inStandby <= 1'b1;
		tk(2);
		r16(4'h8, 16'h0001);
		wr(4'h0, 8'h81);
		tk(2);
		w16(4'h8, 16'h0000);
		tk(4);
		r16(4'h8, 16'h0002);
		inStandby <= 1'b0;
		inIdle <= 1'b1;
		tk(1);
		r16(4'h8, 16'h0003);
		w16(4'h8, 16'h0000);
		wr(4'h0, 8'h00);
		tk(5);
		r16(4'h8, 16'h0000);
		wr(4'h0, 8'h01);
		tk(2);
		for (i = 0; i < 4; i++) begin
			src = i;
			// crystal and pin sources are taken as already running here
			wr(4'h7, i[7:0]);
			w16(4'h8, 16'h0000);
			tk(5);
			r16(4'h8, 16'h0003);
			rdc(4'h7, i[7:0]);
		end
		tk(1);
		test_done;
	end
endmodule
